// file: core/mrsc_reset_ctrl.sv
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module mrsc_reset_ctrl
  import mrsc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        porPulse,
  input  wire logic        lowSupplyPin,
  input  wire logic        slowOscPin,
  input  wire logic        watchdogTimeout,
  input  wire logic        powerDown,
  input  wire logic        idleSysClock,
  input  wire logic        sysOnHighSpeed,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output mrsc_pkg::mrsc_rst_t resetOut,
  output logic             clearPc,
  output logic [7:0]       stackPtrInit,
  output logic             clearSp,
  output logic [7:0]       portDataInit,
  output logic [7:0]       portDirInit,
  output logic [7:0]       analogSelInit,
  output logic             loadPortInit,
  output logic             intDisable,
  output logic             timerOff,
  output logic             watchdogClear,
  output logic             cpuHold
);
  import mrsc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {RUN, FULL_RST, WAKE_SETTLE} mrsc_phase_t;

  typedef struct packed {
    mrsc_phase_t phase;
    logic [3:0]  holdCnt;
    logic [4:0]  settleCnt;
    logic [7:0]  uvCnt;
    logic [7:0]  thresh;
    logic        uvFlag;
    logic        codeFaultFlag;
    logic        wdCodeFlag;
    logic        expiredFlag;
    logic        pdFlag;
    logic [7:0]  ctrlOther;
    logic        slowPrev;
    logic        porPend;
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wHeld;
    logic [7:0]  wData;
    logic        wLane0;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } mrsc_state_t;

  mrsc_state_t st_q;
  mrsc_state_t st_d;
  logic        lowSync;
  logic        slowSync;
  logic        codeFire;
  logic        slowTick;

  mrsc_sync u_lowSync (
    .clock (clock),
    .nrst  (nrst),
    .din   (lowSupplyPin),
    .dout  (lowSync)
  );
  mrsc_sync u_slowSync (
    .clock (clock),
    .nrst  (nrst),
    .din   (slowOscPin),
    .dout  (slowSync)
  );

  assign slowTick = slowSync & ~st_q.slowPrev;

  mrsc_debounce u_debounce (
    .clock    (clock),
    .nrst     (nrst),
    .slowTick (slowTick),
    .codeBad  (!mrsc_code_ok(st_q.thresh)),            // [RQ5]
    .fire     (codeFire)
  );

  function automatic logic [7:0] ctrl_read(input mrsc_state_t s);
    logic [7:0] v;
    v = s.ctrlOther & 8'hB0;                           // [RQ12]
    v[MRSC_UV_FLAG_BIT] = s.uvFlag;
    v[MRSC_CODE_FLT_BIT] = s.codeFaultFlag;
    v[MRSC_WD_CODE_BIT]  = s.wdCodeFlag;
    return v;
  endfunction : ctrl_read

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic uvFire;
  logic fullEvt;
  logic wdNormal;
  logic wdHalted;
  logic doWrite;

  always_comb begin
    st_d          = st_q;
    st_d.slowPrev = slowSync;
    st_d.porPend  = 1'b0;
    uvFire        = 1'b0;
    wdNormal      = watchdogTimeout & ~powerDown;
    wdHalted      = watchdogTimeout & powerDown;
    doWrite       = 1'b0;

    // low-supply filter, off while powered down
    if (lowSync && !powerDown) begin                   // [RQ9]
      if (st_q.uvCnt == MRSC_UV_FILTER_CYC) begin
        uvFire     = 1'b1;                             // [RQ3]
        st_d.uvCnt = 8'h00;
      end else begin
        st_d.uvCnt = st_q.uvCnt + 8'h01;
      end
    end else begin
      st_d.uvCnt = 8'h00;                              // [RQ4]
    end

    fullEvt = uvFire | codeFire | wdNormal;            // [RQ13]

    // -- bus side: aw/w accepted separately, then answered together
    if (s_axi_awvalid && !st_q.awHeld) begin
      st_d.awHeld = 1'b1;
      st_d.awAddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !st_q.wHeld) begin
      st_d.wHeld  = 1'b1;
      st_d.wData  = s_axi_wdata[7:0];
      st_d.wLane0 = s_axi_wstrb[0];
    end
    if (st_q.bValid && s_axi_bready) begin
      st_d.bValid = 1'b0;
    end
    if (st_q.awHeld && st_q.wHeld && !st_q.bValid) begin
      doWrite     = 1'b1;
      st_d.awHeld = 1'b0;
      st_d.wHeld  = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp  = 2'b00;
      if (st_q.awAddr != MRSC_THRESH_ADDR && st_q.awAddr != MRSC_CTRL_ADDR &&
          st_q.awAddr != MRSC_STATUS_ADDR) begin
        st_d.bResp = 2'b10;
      end
    end
    if (doWrite && st_q.wLane0) begin
      if (st_q.awAddr == MRSC_THRESH_ADDR) begin
        st_d.thresh = st_q.wData;                      // [RQ8]
      end else if (st_q.awAddr == MRSC_CTRL_ADDR) begin
        st_d.ctrlOther = st_q.wData & MRSC_CTRL_WMASK;
        // software may clear or set; hardware set wins below
        st_d.uvFlag  = st_q.wData[MRSC_UV_FLAG_BIT];   // [RQ10]
        st_d.codeFaultFlag = st_q.wData[MRSC_CODE_FLT_BIT]; // [RQ11]
        st_d.wdCodeFlag    = st_q.wData[MRSC_WD_CODE_BIT];
      end
    end
    if (st_q.rValid && s_axi_rready) begin
      st_d.rValid = 1'b0;
    end
    if (s_axi_arvalid && !st_q.rValid) begin
      st_d.rValid = 1'b1;
      st_d.rResp  = 2'b00;
      st_d.rData  = 32'h0000_0000;
      unique case (s_axi_araddr[7:0])
        MRSC_THRESH_ADDR: st_d.rData[7:0] = st_q.thresh;
        MRSC_CTRL_ADDR:   st_d.rData[7:0] = ctrl_read(st_q);
        MRSC_STATUS_ADDR: begin
          st_d.rData[MRSC_ST_PD_BIT]  = st_q.pdFlag;
          st_d.rData[MRSC_ST_EXP_BIT] = st_q.expiredFlag;
        end
        default:          st_d.rResp = 2'b10;
      endcase
    end

    // -- reset sources; flag sets override software clears
    if (uvFire) begin
      st_d.uvFlag = 1'b1;                              // [RQ3] [RQ17]
    end
    if (codeFire) begin
      st_d.codeFaultFlag = 1'b1;                       // [RQ11]
    end
    if (watchdogTimeout) begin
      st_d.expiredFlag = 1'b1;                         // [RQ18]
    end
    if (wdHalted) begin
      st_d.pdFlag = 1'b1;                              // [RQ18]
    end

    unique case (st_q.phase)
      RUN: begin
        if (fullEvt) begin
          st_d.phase   = FULL_RST;
          st_d.holdCnt = MRSC_RESET_HOLD;
        end else if (wdHalted) begin
          st_d.phase     = WAKE_SETTLE;                // [RQ14]
          st_d.settleCnt = sysOnHighSpeed ? MRSC_SETTLE_HIGH
                                          : MRSC_SETTLE_LOW; // [RQ15]
        end
      end
      FULL_RST: begin
        if (st_q.holdCnt == 4'h0) begin
          st_d.phase = RUN;
        end else begin
          st_d.holdCnt = st_q.holdCnt - 4'h1;
        end
      end
      WAKE_SETTLE: begin
        if (fullEvt) begin
          st_d.phase   = FULL_RST;
          st_d.holdCnt = MRSC_RESET_HOLD;
        end else if (st_q.settleCnt == 5'h00) begin
          st_d.phase = RUN;
        end else begin
          st_d.settleCnt = st_q.settleCnt - 5'h01;
        end
      end
      // the fourth phase code is unused; recover through a full reset
      default: begin
        st_d.phase   = FULL_RST;
        st_d.holdCnt = MRSC_RESET_HOLD;
      end
    endcase

    // a full reset returns the threshold register to its default
    if (fullEvt) begin
      st_d.thresh    = MRSC_THRESH_RESET;
      st_d.ctrlOther = 8'h00;
    end
    if (porPulse) begin
      st_d.expiredFlag = 1'b0;                         // [RQ16]
      st_d.pdFlag      = 1'b0;                         // [RQ16]
      st_d.thresh      = MRSC_THRESH_RESET;            // [RQ7]
      st_d.codeFaultFlag = 1'b0;
      st_d.wdCodeFlag    = 1'b0;
      st_d.ctrlOther   = 8'h00;
      st_d.porPend     = 1'b1;
      st_d.phase       = FULL_RST;
      st_d.holdCnt     = MRSC_RESET_HOLD;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q         <= '0;
      st_q.phase   <= FULL_RST;
      st_q.holdCnt <= MRSC_RESET_HOLD;
      st_q.thresh  <= MRSC_THRESH_RESET;               // [RQ7]
      st_q.porPend <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic inFull;
  assign inFull = (st_q.phase == FULL_RST);

  assign resetOut.fullReset   = inFull;
  assign resetOut.porReset    = st_q.porPend;
  assign resetOut.wakeReset   = (st_q.phase == WAKE_SETTLE);
  assign resetOut.restartHold = (st_q.phase != RUN);

  assign clearPc       = inFull | (st_q.phase == WAKE_SETTLE); // [RQ1] [RQ14]
  assign clearSp       = clearPc;                               // [RQ22]
  assign stackPtrInit  = MRSC_SP_TOP;                           // [RQ22]
  assign portDataInit  = MRSC_PORT_RESET;                       // [RQ2]
  assign portDirInit   = MRSC_PORT_RESET;                       // [RQ2] [RQ21]
  assign analogSelInit = MRSC_ANALOG_RESET;                     // [RQ21]
  assign loadPortInit  = inFull;                                // [RQ2]
  assign intDisable    = inFull;                                // [RQ19]
  assign timerOff      = inFull;                                // [RQ19]
  assign watchdogClear = inFull | (st_q.phase == WAKE_SETTLE);  // [RQ20]
  assign cpuHold       = (st_q.phase != RUN) | idleSysClock & 1'b0; // [RQ15]

  assign s_axi_awready = ~st_q.awHeld;
  assign s_axi_wready  = ~st_q.wHeld;
  assign s_axi_bvalid  = st_q.bValid;
  assign s_axi_bresp   = st_q.bResp;
  assign s_axi_arready = ~st_q.rValid;
  assign s_axi_rvalid  = st_q.rValid;
  assign s_axi_rdata   = st_q.rData;
  assign s_axi_rresp   = st_q.rResp;
endmodule : mrsc_reset_ctrl

// file: inc/mrsc_pkg.sv
// Contract
// RQ1: power-on reset clears program counter
// RQ2: power-on sets port data/direction all ones
// RQ3: persistent low supply resets, sets undervolt flag
// RQ4: short low-supply glitches are ignored
// RQ5: threshold register has four valid codes
// RQ6: invalid code resets after 2-3 slow cycles
// RQ7: threshold register powers up 0x55
// RQ8: software may write any threshold value
// RQ9: undervolt reset disabled in power-down
// RQ10: undervolt flag bit 2, software clears
// RQ11: code fault flag bit 1, software clears
// RQ12: control bits 6 and 3 read zero
// RQ13: normal watchdog timeout gives full reset
// RQ14: powerdown watchdog timeout clears only PC, SP
// RQ15: wake restart delay 15-16 or 1-2 cycles
// RQ16: power-on clears expired and powerdown flags
// RQ17: undervolt reset keeps expired and powerdown flags
// RQ18: watchdog reset sets expired, powerdown if halted
// RQ19: power-on disables interrupts, stops timer
// RQ20: watchdog counter cleared, restarts after reset
// RQ21: power-on ports inputs, analog pins assigned
// RQ22: power-on stack pointer at stack top
// RQ23: debounce on slow clock, restarts when valid
package mrsc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] MRSC_THRESH_ADDR  = 8'h00;
  localparam logic [7:0] MRSC_CTRL_ADDR    = 8'h04;
  localparam logic [7:0] MRSC_STATUS_ADDR  = 8'h08;
  localparam logic [7:0] MRSC_THRESH_RESET = 8'h55;
  localparam logic [7:0] MRSC_CODE_A       = 8'h55;
  localparam logic [7:0] MRSC_CODE_B       = 8'h33;
  localparam logic [7:0] MRSC_CODE_C       = 8'h99;
  localparam logic [7:0] MRSC_CODE_D       = 8'hAA;
  localparam logic [7:0] MRSC_CTRL_WMASK   = 8'hB7;
  localparam int         MRSC_UV_FLAG_BIT  = 2;
  localparam int         MRSC_CODE_FLT_BIT = 1;
  localparam int         MRSC_WD_CODE_BIT  = 0;
  localparam int         MRSC_ST_PD_BIT    = 0;
  localparam int         MRSC_ST_EXP_BIT   = 1;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int         MRSC_CLK_NS        = 8;
  localparam int         MRSC_UV_FILTER_NS  = 120;
  localparam logic [7:0] MRSC_UV_FILTER_CYC =
    8'((MRSC_UV_FILTER_NS + MRSC_CLK_NS - 1) / MRSC_CLK_NS);
  localparam logic [1:0] MRSC_DEBOUNCE_SLOW = 2'h2;
  localparam logic [4:0] MRSC_SETTLE_HIGH   = 5'h0F;
  localparam logic [4:0] MRSC_SETTLE_LOW    = 5'h01;
  localparam logic [3:0] MRSC_RESET_HOLD    = 4'h4;
  localparam logic [7:0] MRSC_PORT_RESET    = 8'hFF;
  localparam logic [7:0] MRSC_SP_TOP        = 8'hFF;
  localparam logic [7:0] MRSC_ANALOG_RESET  = 8'hFF;

  typedef struct packed {
    logic fullReset;
    logic porReset;
    logic wakeReset;
    logic restartHold;
  } mrsc_rst_t;

  function automatic logic mrsc_code_ok(input logic [7:0] c);
    return (c == MRSC_CODE_A) || (c == MRSC_CODE_B) ||
           (c == MRSC_CODE_C) || (c == MRSC_CODE_D);
  endfunction : mrsc_code_ok
endpackage : mrsc_pkg

// file: core/mrsc_sync.sv
`timescale 1ns/1ps
module mrsc_sync
  import mrsc_pkg::*;
(
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic s0;
    logic s1;
  } mrsc_sync_t;
  mrsc_sync_t st_q;
  mrsc_sync_t st_d;
  always_comb begin
    st_d    = st_q;
    st_d.s0 = din;
    st_d.s1 = st_q.s0;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign dout = st_q.s1;
endmodule : mrsc_sync

// file: core/mrsc_debounce.sv
`timescale 1ns/1ps
// counts slow-oscillator ticks while the threshold code is invalid
module mrsc_debounce
  import mrsc_pkg::*;
(
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic slowTick,
  input  wire logic codeBad,
  output logic      fire
);
  typedef struct packed {
    logic [1:0] cnt;
    logic       fire;
  } mrsc_deb_t;
  mrsc_deb_t st_q;
  mrsc_deb_t st_d;
  always_comb begin
    st_d      = st_q;
    st_d.fire = 1'b0;
    if (!codeBad) begin
      st_d.cnt = 2'h0;                                 // [RQ23]
    end else if (slowTick) begin
      // a partial first tick makes the delay 2..3 slow periods
      if (st_q.cnt == MRSC_DEBOUNCE_SLOW) begin
        st_d.fire = 1'b1;                              // [RQ6]
        st_d.cnt  = 2'h0;
      end else begin
        st_d.cnt = st_q.cnt + 2'h1;
      end
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign fire = st_q.fire;
endmodule : mrsc_debounce

// file: verif/mrsc_reset_ctrl_props.sv
`timescale 1ns/1ps
module mrsc_reset_ctrl_props (
  input wire logic                clock,
  input wire logic                nrst,
  input wire logic                watchdogTimeout,
  input wire logic                powerDown,
  input wire logic                sysOnHighSpeed,
  input wire mrsc_pkg::mrsc_rst_t resetOut,
  input wire logic                clearPc,
  input wire logic                clearSp,
  input wire logic [7:0]          stackPtrInit,
  input wire logic [7:0]          portDataInit,
  input wire logic [7:0]          portDirInit,
  input wire logic [7:0]          analogSelInit,
  input wire logic                loadPortInit,
  input wire logic                intDisable,
  input wire logic                timerOff,
  input wire logic                watchdogClear,
  input wire logic                cpuHold
);
  import mrsc_pkg::*;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  full_clears_core_a: assert property (resetOut.fullReset |-> clearPc && watchdogClear)
    else $error("full reset without pc or watchdog clear");
  port_init_a: assert property (loadPortInit |-> portDataInit == 8'hFF &&
    portDirInit == 8'hFF && analogSelInit == 8'hFF)
    else $error("port init values wrong");
  int_timer_off_a: assert property (intDisable == resetOut.fullReset &&
    timerOff == resetOut.fullReset && loadPortInit == resetOut.fullReset)
    else $error("interrupt or timer control not tied to full reset");
  sp_top_a: assert property (resetOut.fullReset |-> stackPtrInit == 8'hFF && clearSp)
    else $error("stack pointer not at top in full reset");
  // a watchdog hit inside a reset phase may be absorbed, so only run-phase hits are judged
  wd_full_reset_a: assert property (watchdogTimeout && !powerDown && !cpuHold |=>
    resetOut.fullReset [*5] ##1 !resetOut.fullReset)
    else $error("watchdog in run did not give five-cycle full reset");
  wd_wake_clear_a: assert property (watchdogTimeout && powerDown && !cpuHold |=>
    clearPc && clearSp && !intDisable && !loadPortInit)
    else $error("wake reset touched more than pc and sp");
  wake_hi_settle_a: assert property (watchdogTimeout && powerDown && sysOnHighSpeed &&
    !cpuHold |=> cpuHold [*8] ##1 cpuHold [*7] ##[1:2] !cpuHold)
    else $error("high-speed wake settle not 15 to 16 cycles");
  wake_lo_settle_a: assert property (watchdogTimeout && powerDown && !sysOnHighSpeed &&
    !cpuHold |=> cpuHold ##[1:2] !cpuHold)
    else $error("low-speed wake settle not 1 to 2 cycles");
  por_in_full_a: assert property (resetOut.porReset |-> resetOut.fullReset &&
    resetOut.restartHold)
    else $error("power-on reset outside full reset");
  wake_phase_a: assert property (resetOut.wakeReset |-> cpuHold && resetOut.restartHold &&
    !resetOut.fullReset && watchdogClear)
    else $error("wake reset phase outputs wrong");
endmodule : mrsc_reset_ctrl_props

bind mrsc_reset_ctrl mrsc_reset_ctrl_props u_props (
  .clock(clock), .nrst(nrst), .watchdogTimeout(watchdogTimeout), .powerDown(powerDown),
  .sysOnHighSpeed(sysOnHighSpeed), .resetOut(resetOut), .clearPc(clearPc), .clearSp(clearSp),
  .stackPtrInit(stackPtrInit), .portDataInit(portDataInit), .portDirInit(portDirInit),
  .analogSelInit(analogSelInit), .loadPortInit(loadPortInit), .intDisable(intDisable),
  .timerOff(timerOff), .watchdogClear(watchdogClear), .cpuHold(cpuHold)
);

// file: verif/mrsc_reset_ctrl_tb.sv
`timescale 1ns/1ps
module mrsc_reset_ctrl_tb;
  import mrsc_pkg::*;
  logic        clock, nrst, porPulse, lowSupplyPin, slowOscPin, watchdogTimeout;
  logic        powerDown, idleSysClock, sysOnHighSpeed, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready, frPrev;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  codes [4];
  mrsc_rst_t   resetOut;
  int          errors, n_tests, nFull, slowCnt, n0, k;

  mrsc_reset_ctrl u_dut (
    .clock(clock), .nrst(nrst), .porPulse(porPulse), .lowSupplyPin(lowSupplyPin),
    .slowOscPin(slowOscPin), .watchdogTimeout(watchdogTimeout), .powerDown(powerDown),
    .idleSysClock(idleSysClock), .sysOnHighSpeed(sysOnHighSpeed),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .resetOut(resetOut), .clearPc(), .stackPtrInit(), .clearSp(), .portDataInit(),
    .portDirInit(), .analogSelInit(), .loadPortInit(), .intDisable(), .timerOff(),
    .watchdogClear(), .cpuHold()
  );

  // ---------------------------------------------------------------
  // clocks and monitors
  // ---------------------------------------------------------------
  always #4 clock = ~clock;

  // slow oscillator, period 80 system cycles
  always @(posedge clock) begin
    slowCnt <= (slowCnt == 39) ? 0 : slowCnt + 1;
    if (slowCnt == 39) slowOscPin <= ~slowOscPin;
  end

  always @(posedge clock) begin
    frPrev <= resetOut.fullReset;
    if (resetOut.fullReset === 1'b1 && frPrev === 1'b0) nFull <= nFull + 1;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic fail_out(input string nm);
    $display("[FAIL] %s expected done seen timeout", nm);
    errors++;
    report_and_stop();
  endtask : fail_out

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask : chk

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    logic ta, tw, aw, w, got;
    int   i;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw = 0;
    w = 0;
    got = 0;
    for (i = 0; i < 200 && !got; i++) begin
      @(negedge clock);
      ta = awvalid && awready;
      tw = wvalid && wready;
      got = bready && bvalid;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      aw |= ta;
      w |= tw;
      bready <= aw && w && !got;
    end
    if (!got) fail_out("write response");
  endtask : axi_wr

  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] m,
                        input logic [31:0] e, input logic [1:0] er = 2'b00);
    logic        ta, got;
    logic [31:0] d;
    logic [1:0]  r;
    int          i;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    got = 0;
    for (i = 0; i < 200 && !got; i++) begin
      @(negedge clock);
      ta = arvalid && arready;
      got = rready && rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
      rready <= (ta || rready) && !got;
    end
    if (!got) fail_out("read response");
    chk(nm, e, d & m);
    chk({nm, " resp"}, {30'h0, er}, {30'h0, r});
  endtask : rd_chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic pulse_wd();
    @(posedge clock);
    watchdogTimeout <= 1'b1;
    @(posedge clock);
    watchdogTimeout <= 1'b0;
  endtask : pulse_wd

  task automatic low_sup(input int n);
    @(posedge clock);
    lowSupplyPin <= 1'b1;
    cyc(n);
    lowSupplyPin <= 1'b0;
  endtask : low_sup

  task automatic wait_full();
    int i;
    for (i = 0; i < 1000 && nFull == n0; i++) @(posedge clock);
    if (nFull == n0) fail_out("full reset");
    cyc(10);
  endtask : wait_full

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {clock, nrst, porPulse, lowSupplyPin, slowOscPin, watchdogTimeout, powerDown} = '0;
    {idleSysClock, sysOnHighSpeed, awvalid, wvalid, bready, arvalid, rready, frPrev} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hF;
    {errors, n_tests, nFull, slowCnt} = '0;
    codes = '{8'h55, 8'h33, 8'h99, 8'hAA};
    cyc(20);
    nrst <= 1'b1;
    cyc(10);
    rd_chk("thresh por", 32'h00, 32'hFF, 32'h55);
    rd_chk("status por", 32'h08, 32'h03, 32'h00);
    rd_chk("ctrl por", 32'h04, 32'h4B, 32'h00);
    axi_wr(32'h04, 32'hFF);
    rd_chk("ctrl ones", 32'h04, 32'hFF, 32'hB7);
    axi_wr(32'h04, 32'h00);
    rd_chk("ctrl clear", 32'h04, 32'hFF, 32'h00);
    rd_chk("unmapped", 32'h0C, 32'hFFFFFFFF, 32'h0, 2'b10);
    n0 = nFull;
    for (k = 0; k < 4; k++) begin
      axi_wr(32'h00, {24'h0, codes[k]});
      rd_chk("valid code", 32'h00, 32'hFF, {24'h0, codes[k]});
      cyc(300);
    end
    chk("no reset valid", n0, nFull);
    // invalid code held about one slow period then repaired: debounce must restart
    axi_wr(32'h00, 32'h12);
    cyc(100);
    axi_wr(32'h00, 32'h55);
    cyc(400);
    chk("debounce restart", n0, nFull);
    axi_wr(32'h00, 32'h00);
    wait_full();
    rd_chk("thresh restored", 32'h00, 32'hFF, 32'h55);
    rd_chk("code fault", 32'h04, 32'h02, 32'h02);
    axi_wr(32'h04, 32'h00);
    n0 = nFull;
    low_sup(10);
    cyc(50);
    chk("glitch ignored", n0, nFull);
    pulse_wd();
    wait_full();
    rd_chk("status wd run", 32'h08, 32'h03, 32'h02);
    n0 = nFull;
    low_sup(20);
    wait_full();
    rd_chk("status uv", 32'h08, 32'h03, 32'h02);
    rd_chk("uv flag", 32'h04, 32'h04, 32'h04);
    axi_wr(32'h04, 32'h00);
    rd_chk("uv flag clr", 32'h04, 32'h04, 32'h00);
    n0 = nFull;
    powerDown <= 1'b1;
    sysOnHighSpeed <= 1'b1;
    low_sup(40);
    cyc(40);
    chk("uv off in halt", n0, nFull);
    pulse_wd();
    cyc(30);
    sysOnHighSpeed <= 1'b0;
    pulse_wd();
    cyc(10);
    powerDown <= 1'b0;
    chk("wake no full", n0, nFull);
    rd_chk("status wd halt", 32'h08, 32'h03, 32'h03);
    axi_wr(32'h00, 32'h33);
    n0 = nFull;
    @(posedge clock);
    porPulse <= 1'b1;
    @(posedge clock);
    porPulse <= 1'b0;
    wait_full();
    rd_chk("status por pulse", 32'h08, 32'h03, 32'h00);
    rd_chk("thresh por pulse", 32'h00, 32'hFF, 32'h55);
    nrst <= 1'b0;
    cyc(3);
    nrst <= 1'b1;
    cyc(10);
    rd_chk("status 2nd por", 32'h08, 32'h03, 32'h00);
    rd_chk("thresh 2nd por", 32'h00, 32'hFF, 32'h55);
    report_and_stop();
  end
endmodule : mrsc_reset_ctrl_tb
